// ### pkg/sriu_defs.vh
// Register map, field positions and frame constants of the serial unit
`ifndef SRIU_DEFS_VH
`define SRIU_DEFS_VH
`define SRIU_A_HBRIDGE_OUTPUT   5'h01
`define SRIU_A_HBRIDGE_CONTROL   5'h02
`define SRIU_A_SYSTEM_CONTROL  5'h03
`define SRIU_A_IMR     5'h04
`define SRIU_A_IFR     5'h05
`define SRIU_A_RMR     5'h06
`define SRIU_A_ANALOG_MUX_SELECT   5'h07
`define SRIU_A_HALL_INPUT_ENABLE   5'h08
`define SRIU_A_HALL_INPUT_STATE  5'h09
`define SRIU_A_AUTONOMOUS_WATCHDOG_CONTROL  5'h0a
`define SRIU_A_POWER_OUTPUT_CONTROL    5'h0b
`define SRIU_A_SYSTEM_STATUS 5'h0c
`define SRIU_M_HBRIDGE_OUTPUT   8'hff
`define SRIU_M_HBRIDGE_CONTROL   8'he7
`define SRIU_M_SYSTEM_CONTROL  8'he0
`define SRIU_M_IMR     8'h7e
`define SRIU_M_RMR     8'h83
`define SRIU_M_ANALOG_MUX_SELECT   8'h0f
`define SRIU_M_HALL_INPUT_ENABLE   8'h07
`define SRIU_M_AUTONOMOUS_WATCHDOG_CONTROL  8'h3f
`define SRIU_M_POWER_OUTPUT_CONTROL    8'h3f
`define SRIU_RST_BYTE  8'h00
`define SRIU_RST_MAIN_REGULATOR  1'b1
`define SRIU_HB_HIGH   8'haa
`define SRIU_B_HALL    6
`define SRIU_B_BUS     5
`define SRIU_B_OT      4
`define SRIU_B_UV      3
`define SRIU_B_OV      2
`define SRIU_B_OC      1
`define SRIU_B_AWDIE   3
`define SRIU_B_CYCLIC_CHECK_ENABLE   2
`define SRIU_B_HSON    0
`define SRIU_B_HVDDON  1
`define SRIU_B_GS      0
`define SRIU_FRAME_EDGES 5'd16
`define SRIU_PARITY_EDGE 5'd6
`endif

// ### logic/sriu_core.v
// Serial register bank, interrupt flags and stop-mode wake-up logic
//
// Notes on behaviour
// - Interrupt enables are written over the serial link; all cleared by reset.
// - Supply undervoltage sets its flag; interrupts only with its enable set.
// - Supply overvoltage sets its flag; interrupts only with its enable set.
// - Under- or overvoltage turns off bridge upper switches and high side.
// - Overtemperature sets its flag; interrupts only with its enable set.
// - In stop mode voltage and temperature detection is off.
// - Bus line falling edge interrupts when enabled; wakes in stop mode.
// - Enabled hall input activity interrupts; cyclic check wakes in stop.
// - Overcurrent on bridge, high side or sensor supply is flagged.
// - Bus edge, watchdog, hall check or low logic supply wakes system.
// - Frames are command plus data in; status plus register data out.
// - Select low drives the serial output; select high releases it.
// - Output changes on clock rise; input sampled on clock fall.
// - Only frames with exactly sixteen falling clock edges are valid.
// - Write data enters the register on the rising edge of select.
// - Read data is captured while the parity bit is shifted.
// - Command holds five address bits, direction, parity, one spare.
// - Direction one reads; zero writes and returns the old value.
// - Parity is even parity count over direction and address bits.
// - Parity is checked on writes only.
// - First returned byte is always the system status register.
// - Writing one clears a flag, zero has no effect; reset clears.
// - Voltage and temperature flags stay set while condition persists.
// - Overcurrent flag is read-only; cleared through system status bits.
// - Each enable gates its flag onto the interrupt; reset to zero.
`timescale 1ns/1ps
`include "sriu_defs.vh"

module sriu_core (
    input  wire       clock,
    input  wire       rst_n,
    input  wire       ss_n,
    input  wire       sclk,
    input  wire       mosi,
    output reg        miso_o,
    output reg        miso_oe_n,
    output reg        irq_o,
    output reg        irq_oe_n,
    input  wire       supply_undervoltage_event,
    input  wire       supply_overvoltage_event,
    input  wire       overtemperature_event,
    input  wire       oc_hbridge,
    input  wire       oc_high_side,
    input  wire       oc_sensor_supply,
    input  wire       oc_hall_pin,
    input  wire       bus_line,
    input  wire [2:0] hall_inputs,
    input  wire       autonomous_watchdog_wake,
    input  wire       logic_supply_low_reset,
    input  wire       stop_mode,
    output reg  [7:0] hb_gate_q,
    output reg        hs_on_q,
    output reg        switched_sensor_supply_on_q,
    output reg        wake_q,
    output reg        main_regulator_on_q,
    output reg        stop_request_q
);

    localparam ST_IDLE = 2'b01;
    localparam ST_ACT  = 2'b10;

    // All pins pass two flops before use
    wire [16:0] raw = {ss_n, sclk, mosi, supply_undervoltage_event,
                       supply_overvoltage_event, overtemperature_event,
                       oc_hbridge, oc_high_side, oc_sensor_supply,
                       oc_hall_pin, bus_line, hall_inputs,
                       autonomous_watchdog_wake, logic_supply_low_reset,
                       stop_mode};
    reg  [16:0] s1_q;
    reg  [16:0] s2_q;
    wire        ss_s;
    wire        sclk_s;
    wire        mosi_s;
    wire        uv_s;
    wire        ov_s;
    wire        ot_s;
    wire        ochb_s;
    wire        ochs_s;
    wire        ochv_s;
    wire        ochp_s;
    wire        bus_s;
    wire [2:0]  hall_s;
    wire        awd_s;
    wire        lvr_s;
    wire        stop_s;
    assign {ss_s, sclk_s, mosi_s, uv_s, ov_s, ot_s, ochb_s, ochs_s, ochv_s,
            ochp_s, bus_s, hall_s, awd_s, lvr_s, stop_s} = s2_q;

    reg         ss_p_q;
    reg         sclk_p_q;
    reg         bus_p_q;
    reg         stop_p_q;
    reg  [2:0]  hall_p_q;
    reg  [1:0]  state_q;
    reg  [4:0]  rise_cnt_q;
    reg  [4:0]  fall_cnt_q;
    reg  [15:0] rx_q;
    reg  [15:0] tx_q;

    reg  [7:0]  hbridge_output_q;
    reg  [7:0]  hbridge_control_q;
    reg  [7:0]  system_control_q;
    reg  [7:0]  imr_q;
    reg  [7:0]  ifr_q;
    reg  [7:0]  rmr_q;
    reg  [7:0]  analog_mux_select_q;
    reg  [7:0]  hall_input_enable_q;
    reg  [7:0]  autonomous_watchdog_control_q;
    reg  [7:0]  power_output_control_q;
    reg         hp_oc_q;
    reg         hv_oc_q;
    reg         hs_oc_q;
    reg         hb_oc_q;

    wire ss_fall   = ss_p_q & ~ss_s;
    wire ss_rise   = ~ss_p_q & ss_s;
    wire sclk_rise = ~sclk_p_q & sclk_s;
    wire sclk_fall = sclk_p_q & ~sclk_s;
    wire bus_fall  = bus_p_q & ~bus_s;
    wire stop_rise = ~stop_p_q & stop_s;

    wire uv_c  = uv_s & ~stop_s;
    wire ov_c  = ov_s & ~stop_s;
    wire ot_c  = ot_s & ~stop_s;

    wire [7:0] system_status = {hp_oc_q, 1'b0, hv_oc_q, hs_oc_q,
                          uv_c, ov_c, hb_oc_q, ot_c};
    wire       oc_any  = hb_oc_q | hs_oc_q | hv_oc_q;
    wire [7:0] ifr_rd  = {ifr_q[7:2], oc_any, 1'b0};
    wire [2:0] hen     = hall_input_enable_q[2:0];
    wire       cyc     = autonomous_watchdog_control_q[`SRIU_B_CYCLIC_CHECK_ENABLE];
    wire       hall_hi = |(hall_s & hen);
    wire       hall_ev = stop_s ? (cyc & hall_hi)
                                : |((hall_s ^ hall_p_q) & hen);

    wire       par_ok  = rx_q[9] == ^rx_q[15:10];
    wire       wr_en   = (state_q == ST_ACT) & ss_rise
                         & (fall_cnt_q == `SRIU_FRAME_EDGES)
                         & ~rx_q[15] & par_ok;
    wire [4:0] wr_addr = rx_q[14:10];
    wire [7:0] wr_data = rx_q[7:0];
    wire [7:0] clr     = wr_en & (wr_addr == `SRIU_A_IFR) ? wr_data : 8'h00;
    wire [7:0] sclr    = wr_en & (wr_addr == `SRIU_A_SYSTEM_STATUS) ? wr_data
                                                              : 8'h00;
    wire       fault   = uv_c | ov_c;

    function [7:0] reg_read;
        input [4:0] a;
        begin
            case (a)
                `SRIU_A_HBRIDGE_OUTPUT:   reg_read = hbridge_output_q;
                `SRIU_A_HBRIDGE_CONTROL:   reg_read = hbridge_control_q;
                `SRIU_A_SYSTEM_CONTROL:  reg_read = system_control_q;
                `SRIU_A_IMR:     reg_read = imr_q;
                `SRIU_A_IFR:     reg_read = ifr_rd;
                `SRIU_A_RMR:     reg_read = rmr_q;
                `SRIU_A_ANALOG_MUX_SELECT:   reg_read = analog_mux_select_q;
                `SRIU_A_HALL_INPUT_ENABLE:   reg_read = hall_input_enable_q;
                `SRIU_A_HALL_INPUT_STATE:  reg_read = {5'h00, hall_s};
                `SRIU_A_AUTONOMOUS_WATCHDOG_CONTROL:  reg_read = autonomous_watchdog_control_q;
                `SRIU_A_POWER_OUTPUT_CONTROL:    reg_read = power_output_control_q;
                `SRIU_A_SYSTEM_STATUS: reg_read = system_status;
                default:         reg_read = 8'h00;
            endcase
        end
    endfunction

    function [7:0] merge;
        input [7:0] old;
        input [7:0] val;
        input [7:0] msk;
        begin
            merge = (old & ~msk) | (val & msk);
        end
    endfunction

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Idle pin levels, so no false edge follows reset
            s1_q       <= 17'h10040;
            s2_q       <= 17'h10040;
            ss_p_q     <= 1'b1;
            sclk_p_q   <= 1'b0;
            bus_p_q    <= 1'b1;
            stop_p_q   <= 1'b0;
            hall_p_q   <= 3'h0;
        end else begin
            s1_q       <= raw;
            s2_q       <= s1_q;
            ss_p_q     <= ss_s;
            sclk_p_q   <= sclk_s;
            bus_p_q    <= bus_s;
            stop_p_q   <= stop_s;
            hall_p_q   <= hall_s;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ST_IDLE;
            rise_cnt_q <= 5'h00;
            fall_cnt_q <= 5'h00;
            rx_q       <= 16'h0000;
            tx_q       <= 16'h0000;
            miso_o     <= 1'b0;
            miso_oe_n  <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    miso_oe_n <= 1'b1;
                    if (ss_fall) begin
                        miso_oe_n  <= 1'b0;
                        state_q    <= ST_ACT;
                        rise_cnt_q <= 5'h00;
                        fall_cnt_q <= 5'h00;
                        tx_q       <= {system_status, 8'h00};
                    end
                end
                ST_ACT: begin
                    if (ss_rise) begin
                        miso_oe_n <= 1'b1;
                        state_q   <= ST_IDLE;
                    end else begin
                        if (sclk_rise && !rise_cnt_q[4]) begin
                            miso_o     <= tx_q[~rise_cnt_q[3:0]];
                            rise_cnt_q <= rise_cnt_q + 5'd1;
                        end
                        if (sclk_fall) begin
                            rx_q <= {rx_q[14:0], mosi_s};
                            if (fall_cnt_q != 5'h1f)
                                fall_cnt_q <= fall_cnt_q + 5'd1;
                            if (fall_cnt_q == `SRIU_PARITY_EDGE)
                                tx_q[7:0] <= reg_read(rx_q[4:0]);
                        end
                    end
                end
                default: begin
                    state_q   <= ST_IDLE;
                    miso_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Register bank, flags and outputs
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hbridge_output_q    <= `SRIU_RST_BYTE;
            hbridge_control_q    <= `SRIU_RST_BYTE;
            system_control_q   <= `SRIU_RST_BYTE;
            imr_q      <= `SRIU_RST_BYTE;
            ifr_q      <= `SRIU_RST_BYTE;
            rmr_q      <= `SRIU_RST_BYTE;
            analog_mux_select_q    <= `SRIU_RST_BYTE;
            hall_input_enable_q    <= `SRIU_RST_BYTE;
            autonomous_watchdog_control_q   <= `SRIU_RST_BYTE;
            power_output_control_q     <= `SRIU_RST_BYTE;
            hp_oc_q    <= 1'b0;
            hv_oc_q    <= 1'b0;
            hs_oc_q    <= 1'b0;
            hb_oc_q    <= 1'b0;
            irq_o      <= 1'b0;
            irq_oe_n   <= 1'b1;
            hb_gate_q  <= 8'h00;
            hs_on_q    <= 1'b0;
            switched_sensor_supply_on_q <= 1'b0;
            wake_q     <= 1'b0;
            main_regulator_on_q <= `SRIU_RST_MAIN_REGULATOR;
            stop_request_q <= 1'b0;
        end else begin
            if (wr_en) begin
                case (wr_addr)
                    `SRIU_A_HBRIDGE_OUTPUT:
                        hbridge_output_q <= merge(hbridge_output_q, wr_data, `SRIU_M_HBRIDGE_OUTPUT);
                    `SRIU_A_HBRIDGE_CONTROL:
                        hbridge_control_q <= merge(hbridge_control_q, wr_data, `SRIU_M_HBRIDGE_CONTROL);
                    `SRIU_A_SYSTEM_CONTROL:
                        system_control_q <= merge(system_control_q, wr_data, `SRIU_M_SYSTEM_CONTROL);
                    `SRIU_A_IMR:
                        imr_q <= merge(imr_q, wr_data, `SRIU_M_IMR);
                    `SRIU_A_RMR:
                        rmr_q <= merge(rmr_q, wr_data, `SRIU_M_RMR);
                    `SRIU_A_ANALOG_MUX_SELECT:
                        analog_mux_select_q <= merge(analog_mux_select_q, wr_data, `SRIU_M_ANALOG_MUX_SELECT);
                    `SRIU_A_HALL_INPUT_ENABLE:
                        hall_input_enable_q <= merge(hall_input_enable_q, wr_data, `SRIU_M_HALL_INPUT_ENABLE);
                    `SRIU_A_AUTONOMOUS_WATCHDOG_CONTROL:
                        autonomous_watchdog_control_q <= merge(autonomous_watchdog_control_q, wr_data, `SRIU_M_AUTONOMOUS_WATCHDOG_CONTROL);
                    `SRIU_A_POWER_OUTPUT_CONTROL:
                        power_output_control_q <= merge(power_output_control_q, wr_data, `SRIU_M_POWER_OUTPUT_CONTROL);
                    default: ;
                endcase
            end
            // Go-to-stop bit is write-only, seen as a pulse
            stop_request_q <= wr_en & (wr_addr == `SRIU_A_SYSTEM_CONTROL)
                              & wr_data[`SRIU_B_GS];
            ifr_q[`SRIU_B_HALL] <= (ifr_q[`SRIU_B_HALL]
                                   & ~clr[`SRIU_B_HALL]) | hall_ev;
            ifr_q[`SRIU_B_BUS]  <= (ifr_q[`SRIU_B_BUS]
                                   & ~clr[`SRIU_B_BUS]) | bus_fall;
            ifr_q[`SRIU_B_OT]   <= (ifr_q[`SRIU_B_OT]
                                   & ~clr[`SRIU_B_OT]) | ot_c;
            ifr_q[`SRIU_B_UV]   <= (ifr_q[`SRIU_B_UV]
                                   & ~clr[`SRIU_B_UV]) | uv_c;
            ifr_q[`SRIU_B_OV]   <= (ifr_q[`SRIU_B_OV]
                                   & ~clr[`SRIU_B_OV]) | ov_c;
            hp_oc_q <= (hp_oc_q & ~sclr[7]) | ochp_s;
            hv_oc_q <= (hv_oc_q & ~sclr[5]) | ochv_s;
            hs_oc_q <= (hs_oc_q & ~sclr[4]) | ochs_s;
            hb_oc_q <= (hb_oc_q & ~sclr[1]) | ochb_s;
            irq_oe_n <= ~|(ifr_rd & imr_q);
            // cut upper switches on supply fault
            hb_gate_q <= hbridge_output_q & ~(fault ? `SRIU_HB_HIGH : 8'h00);
            hs_on_q   <= power_output_control_q[`SRIU_B_HSON] & ~fault;
            switched_sensor_supply_on_q <= power_output_control_q[`SRIU_B_HVDDON];
            wake_q <= stop_s & ((bus_fall & imr_q[`SRIU_B_BUS])
                     | (awd_s & autonomous_watchdog_control_q[`SRIU_B_AWDIE])
                     | (cyc & hall_hi & imr_q[`SRIU_B_HALL])
                     | lvr_s);
            // Regulator stays off from stop entry until a wake
            if (wake_q)
                main_regulator_on_q <= 1'b1;
            else if (stop_rise)
                main_regulator_on_q <= 1'b0;
        end
    end

endmodule // sriu_core

// ### sim/sriu_core_asserts.sv
// Port assertions for the serial register unit
`timescale 1ns/1ps
`include "sriu_defs.vh"

module sriu_chk (
    input wire       clock,
    input wire       rst_n,
    input wire       ss_n,
    input wire       sclk,
    input wire       stop_mode,
    input wire       miso_o,
    input wire       miso_oe_n,
    input wire       irq_oe_n,
    input wire       supply_undervoltage_event,
    input wire       supply_overvoltage_event,
    input wire       logic_supply_low_reset,
    input wire [7:0] hb_gate_q,
    input wire       hs_on_q,
    input wire       wake_q,
    input wire       main_regulator_on_q,
    input wire       stop_request_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Pin changes need three flops to show
    sequence s_released;
        ss_n [*5];
    endsequence
    sequence s_selected;
        !ss_n [*6];
    endsequence
    sequence s_low_phase;
        (!ss_n && sclk) ##1 (!ss_n && !sclk) [*3];
    endsequence
    sequence s_supply_fault;
        ((supply_undervoltage_event || supply_overvoltage_event)
            && !stop_mode) [*5];
    endsequence

    a_out_released: assert property (s_released |-> miso_oe_n)
        else $error("miso driven while deselected");
    a_out_driven: assert property (s_selected |-> !miso_oe_n)
        else $error("miso not driven while selected");
    a_bit_steady: assert property (s_low_phase |-> $stable(miso_o))
        else $error("miso moved while serial clock low");
    a_reset_quiet: assert property ($rose(rst_n) |-> irq_oe_n [*8])
        else $error("interrupt right after reset");
    a_fault_cut: assert property (s_supply_fault |->
        (hb_gate_q & `SRIU_HB_HIGH) == 8'h00 && !hs_on_q)
        else $error("upper switches on during supply fault");
    a_low_wake: assert property (
        (stop_mode && logic_supply_low_reset) [*4] |-> ##[0:4] wake_q)
        else $error("no wake on low logic supply");
    a_run_no_wake: assert property ((!stop_mode) [*6] |-> !wake_q)
        else $error("wake outside stop");
    a_reg_restore: assert property (wake_q |-> ##[0:3] main_regulator_on_q)
        else $error("regulator not restored on wake");
    a_stop_pulse: assert property (
        stop_request_q |-> ss_n ##1 !stop_request_q)
        else $error("stop request not a pulse at deselect");
endmodule // sriu_chk

bind sriu_core sriu_chk u_chk (.clock, .rst_n, .ss_n, .sclk, .stop_mode,
    .miso_o, .miso_oe_n, .irq_oe_n, .supply_undervoltage_event,
    .supply_overvoltage_event, .logic_supply_low_reset, .hb_gate_q,
    .hs_on_q, .wake_q, .main_regulator_on_q, .stop_request_q);

// ### sim/sriu_host_model.sv
// Behavioural serial master driving the unit
`timescale 1ns/1ps

module sriu_host (
    input  wire clock,
    input  wire miso_o,
    input  wire miso_oe_n,
    output reg  ss_n,
    output reg  sclk,
    output reg  mosi
);
    reg  hold_q;
    // released line shows the inverse of its last level
    wire miso_line = miso_oe_n ? ~hold_q : miso_o;

    initial begin
        ss_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        hold_q = 1'b0;
    end

    always @(posedge clock) begin
        if (!miso_oe_n) begin
            hold_q <= miso_o;
        end
    end

    // two bytes msb first, sample before next rise
    task frame(input [15:0] tx, input integer n, output [15:0] rx);
        integer i;
        begin
            rx = 16'h0000;
            #7;
            ss_n = 1'b0;
            #320;
            for (i = 0; i < n; i = i + 1) begin
                sclk = 1'b1;
                mosi = (i < 16) ? tx[15 - i] : ~mosi;
                #160;
                sclk = 1'b0;
                #150;
                rx = {rx[14:0], miso_line};
                #10;
            end
            ss_n = 1'b1;
            #480;
        end
    endtask
endmodule // sriu_host

// ### sim/tb_top.sv
// Self-checking bench for the serial register unit
`timescale 1ns/1ps
`include "sriu_defs.vh"

module tb_top;
    reg        clock, rst_n, bus, lslr, stp, autonomous_watchdog;
    reg  [2:0] lv;
    reg  [3:0] oc;
    reg  [2:0] hall;
    reg  [7:0] seed;
    reg  [7:0] m [0:15];
    reg  [7:0] msk [0:15];
    reg [15:0] rx;
    integer    fails, cmp_count, cyc, i, k, hit;
    wire       ss_n, sclk, mosi, miso_o, miso_oe_n, irq_o, irq_oe_n;
    wire [7:0] hb_gate;
    wire       hs_on, ssup_on, wake, reg_on, stop_req;

    sriu_core u_dut (.clock(clock), .rst_n(rst_n), .ss_n(ss_n), .sclk(sclk),
        .mosi(mosi), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .irq_o(irq_o),
        .irq_oe_n(irq_oe_n), .supply_undervoltage_event(lv[0]),
        .supply_overvoltage_event(lv[1]), .overtemperature_event(lv[2]),
        .oc_hbridge(oc[0]), .oc_high_side(oc[1]), .oc_sensor_supply(oc[2]),
        .oc_hall_pin(oc[3]), .bus_line(bus), .hall_inputs(hall),
        .autonomous_watchdog_wake(autonomous_watchdog), .logic_supply_low_reset(lslr),
        .stop_mode(stp), .hb_gate_q(hb_gate), .hs_on_q(hs_on),
        .switched_sensor_supply_on_q(ssup_on), .wake_q(wake),
        .main_regulator_on_q(reg_on), .stop_request_q(stop_req));
    sriu_host u_host (.clock(clock), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
        .ss_n(ss_n), .sclk(sclk), .mosi(mosi));

    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Flag of under, over and temperature levels
    function [7:0] fbit(input integer j);
        fbit = (j == 0) ? 8'h08 : (j == 1) ? 8'h04 : 8'h10;
    endfunction
    function [7:0] obit(input integer j);
        obit = (j == 0) ? 8'h02 : (j == 1) ? 8'h10 : (j == 2) ? 8'h20 : 8'h80;
    endfunction

    task check8(input [7:0] got, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Parity xor over direction and address, bp spoils it
    task xfer(input d, input [4:0] a, input [7:0] wd, input integer n,
              input bp);
        begin
            @(negedge clock);
            u_host.frame({d, a, ^{d, a} ^ bp, 1'b0, wd}, n, rx);
        end
    endtask
    task rd(input [4:0] a, input [7:0] e);
        begin
            seed = lfsr(seed);
            xfer(1'b1, a, seed, 16, 1'b0);
            check8(rx[7:0], e);
        end
    endtask
    task wr(input [4:0] a, input [7:0] d);
        begin
            xfer(1'b0, a, d, 16, 1'b0);
            check8(rx[7:0], m[a]);
            m[a] = d & msk[a];
        end
    endtask
    task see_wake;
        begin
            hit = 0;
            repeat (12) @(negedge clock) if (wake === 1'b1) hit = 1;
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, fails);
            if (fails == 0 && cmp_count > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Hang guard, frames take about 150 cycles
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            fails = fails + 1;
            tally_and_finish;
        end
    end

    initial begin
        rst_n = 1'b0;
        {bus, lslr, stp, autonomous_watchdog, lv, oc, hall} = 14'h2000;
        {fails, cmp_count, cyc} = 0;
        seed = 8'h23;
        for (i = 0; i < 16; i = i + 1) begin
            m[i] = 8'h00;
            msk[i] = 8'h00;
        end
        msk[1] = `SRIU_M_HBRIDGE_OUTPUT;
        msk[2] = `SRIU_M_HBRIDGE_CONTROL;
        msk[3] = `SRIU_M_SYSTEM_CONTROL;
        msk[4] = `SRIU_M_IMR;
        msk[6] = `SRIU_M_RMR;
        msk[7] = `SRIU_M_ANALOG_MUX_SELECT;
        msk[8] = `SRIU_M_HALL_INPUT_ENABLE;
        msk[10] = `SRIU_M_AUTONOMOUS_WATCHDOG_CONTROL;
        msk[11] = `SRIU_M_POWER_OUTPUT_CONTROL;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        check8({7'h00, reg_on}, 8'h01);
        for (i = 1; i < 13; i = i + 1) begin
            rd(i[4:0], 8'h00);
            check8(rx[15:8], 8'h00);
        end
        for (k = 0; k < 3; k = k + 1)
            for (i = 1; i < 12; i = i + 1)
                if (msk[i] != 8'h00) begin
                    seed = lfsr(seed);
                    wr(i[4:0], seed);
                    rd(i[4:0], m[i]);
                end
        check8(hb_gate, m[1]);
        check8({6'h00, ssup_on, hs_on}, m[11] & 8'h03);
        seed = lfsr(seed);
        xfer(1'b0, 5'h01, seed, 16, 1'b1);
        xfer(1'b0, 5'h01, seed, 15, 1'b0);
        xfer(1'b0, 5'h01, seed, 17, 1'b0);
        xfer(1'b1, 5'h01, seed, 16, 1'b1);
        check8(rx[7:0], m[1]);
        xfer(1'b0, 5'h1f, 8'hff, 16, 1'b0);
        rd(5'h1f, 8'h00);
        xfer(1'b0, 5'h09, 8'hff, 16, 1'b0);
        rd(5'h09, 8'h00);
        wr(5'h03, 8'h01);
        for (k = 0; k < 3; k = k + 1) begin
            wr(5'h04, 8'h00);
            @(negedge clock) lv[k] = 1'b1;
            repeat (8) @(negedge clock);
            check8({7'h00, irq_oe_n}, 8'h01);
            check8(hb_gate, (k < 2) ? m[1] & 8'h55 : m[1]);
            check8({7'h00, hs_on}, (k < 2) ? 8'h00 : m[11] & 8'h01);
            xfer(1'b0, 5'h05, fbit(k), 16, 1'b0);
            check8(rx[15:8], (k == 2) ? 8'h01 : fbit(k));
            rd(5'h05, fbit(k));
            wr(5'h04, fbit(k));
            check8({7'h00, irq_oe_n}, 8'h00);
            @(negedge clock) lv[k] = 1'b0;
            repeat (8) @(negedge clock);
            xfer(1'b0, 5'h05, fbit(k), 16, 1'b0);
            rd(5'h05, 8'h00);
            check8({7'h00, irq_oe_n}, 8'h01);
        end
        wr(5'h04, 8'h00);
        @(negedge clock) stp = 1'b1;
        lv[0] = 1'b1;
        repeat (8) @(negedge clock);
        check8({7'h00, reg_on}, 8'h00);
        bus = 1'b0;
        see_wake;
        check8(hit[7:0], 8'h00);
        bus = 1'b1;
        wr(5'h04, 8'h20);
        @(negedge clock) bus = 1'b0;
        see_wake;
        check8(hit[7:0], 8'h01);
        check8({7'h00, reg_on}, 8'h01);
        lslr = 1'b1;
        repeat (8) @(negedge clock);
        lslr = 1'b0;
        rd(5'h05, 8'h20);
        wr(5'h0a, 8'h04);
        @(negedge clock) autonomous_watchdog = 1'b1;
        see_wake;
        check8(hit[7:0], 8'h00);
        wr(5'h0a, 8'h0c);
        see_wake;
        check8(hit[7:0], 8'h01);
        autonomous_watchdog = 1'b0;
        wr(5'h08, 8'h01);
        wr(5'h04, 8'h60);
        @(negedge clock) hall = 3'b001;
        see_wake;
        check8(hit[7:0], 8'h01);
        rd(5'h05, 8'h60);
        @(negedge clock) hall = 3'b000;
        @(negedge clock) lv[0] = 1'b0;
        stp = 1'b0;
        bus = 1'b1;
        check8({7'h00, irq_oe_n}, 8'h00);
        check8({7'h00, irq_o}, 8'h00);
        xfer(1'b0, 5'h05, 8'h60, 16, 1'b0);
        wr(5'h04, 8'h02);
        for (k = 0; k < 4; k = k + 1) begin
            @(negedge clock) oc[k] = 1'b1;
            repeat (8) @(negedge clock);
            oc[k] = 1'b0;
            repeat (8) @(negedge clock);
            xfer(1'b0, 5'h05, 8'h02, 16, 1'b0);
            check8(rx[15:8], obit(k));
            rd(5'h05, (k < 3) ? 8'h02 : 8'h00);
            check8({7'h00, irq_oe_n}, (k < 3) ? 8'h00 : 8'h01);
            xfer(1'b0, 5'h0c, obit(k), 16, 1'b0);
            rd(5'h0c, 8'h00);
            rd(5'h05, 8'h00);
        end
        wr(5'h08, 8'h01);
        wr(5'h04, 8'h40);
        @(negedge clock) hall = 3'b001;
        repeat (8) @(negedge clock);
        rd(5'h09, 8'h01);
        rd(5'h05, 8'h40);
        check8({7'h00, irq_oe_n}, 8'h00);
        xfer(1'b0, 5'h05, 8'h40, 16, 1'b0);
        @(negedge clock) hall = 3'b011;
        repeat (8) @(negedge clock);
        rd(5'h05, 8'h00);
        tally_and_finish;
    end
endmodule // tb_top
